// ### inc/iam_defs.svh
// constants of the illegal access monitor
`ifndef IAM_DEFS_SVH
`define IAM_DEFS_SVH

`define IAM_ADDR_W        24
`define IAM_N_REGIONS     8
`define IAM_REG_BASE      24'h000000
`define IAM_REG_LAST      24'h000FFF
`define IAM_RAM_BASE      24'h001000
`define IAM_RAM_LAST      24'h0017FF
`define IAM_EE_BASE       24'h100000
`define IAM_EE_LAST       24'h10007F
`define IAM_RSV_BASE      24'h200000
`define IAM_RSV_LAST      24'h2FFFFF
`define IAM_RO_BASE       24'h300000
`define IAM_RO_LAST       24'h3FFFFF
`define IAM_IFR_BASE      24'h400000
`define IAM_IFR_LAST      24'h4000FF
`define IAM_PFL_BASE      24'hFFC000
`define IAM_PFL_LAST      24'hFFFFFF
`define IAM_FLAG_RESET    1'b0

`endif

// ### inc/iam_pkg.sv
// types of the illegal access monitor
package iam_pkg;

  typedef enum logic [1:0] {
    IAM_MST_CORE  = 2'h0,
    IAM_MST_DEBUG = 2'h1,
    IAM_MST_CONV  = 2'h2
  } iam_master_t;

  typedef enum logic [1:0] {
    IAM_ACC_READ  = 2'h0,
    IAM_ACC_WRITE = 2'h1,
    IAM_ACC_FETCH = 2'h2
  } iam_access_t;

  typedef enum logic [2:0] {
    IAM_RGN_REG   = 3'h0,
    IAM_RGN_RAM   = 3'h1,
    IAM_RGN_EE    = 3'h2,
    IAM_RGN_RSV   = 3'h3,
    IAM_RGN_RO    = 3'h4,
    IAM_RGN_IFR   = 3'h5,
    IAM_RGN_PFL   = 3'h6,
    IAM_RGN_UNMAP = 3'h7
  } iam_region_t;

endpackage

// ### design/iam_region_decode.sv
// address to region decoder with registered result
`timescale 1ns/1ps
`include "iam_defs.svh"

module iam_region_decode #(
  parameter int ADDR_W = `IAM_ADDR_W
) (
  input  wire logic                core_clk,
  input  wire logic                resetn,
  input  wire logic                clkEn,
  input  wire logic [ADDR_W-1:0]   addr,
  output iam_pkg::iam_region_t     region
);
  import iam_pkg::*;

  // refuse widths the fixed memory map cannot serve
  if (ADDR_W != `IAM_ADDR_W) begin : g_bad_width
    $error("iam_region_decode: address width must be 24");
  end

  function automatic logic inRange(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] lo,
                                   input logic [ADDR_W-1:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction

  logic [`IAM_N_REGIONS-2:0] hit;
  iam_region_t               next_region;

  localparam logic [ADDR_W-1:0] RGN_LO [`IAM_N_REGIONS-1] = '{
    `IAM_REG_BASE, `IAM_RAM_BASE, `IAM_EE_BASE, `IAM_RSV_BASE,
    `IAM_RO_BASE, `IAM_IFR_BASE, `IAM_PFL_BASE
  };
  localparam logic [ADDR_W-1:0] RGN_HI [`IAM_N_REGIONS-1] = '{
    `IAM_REG_LAST, `IAM_RAM_LAST, `IAM_EE_LAST, `IAM_RSV_LAST,
    `IAM_RO_LAST, `IAM_IFR_LAST, `IAM_PFL_LAST
  };

  // one window compare per mapped region
  for (genvar gi = 0; gi < `IAM_N_REGIONS - 1; gi++) begin : g_hit
    assign hit[gi] = inRange(addr, RGN_LO[gi], RGN_HI[gi]);
  end

  assign next_region = hit[0] ? IAM_RGN_REG :
                       hit[1] ? IAM_RGN_RAM :
                       hit[2] ? IAM_RGN_EE  :
                       hit[3] ? IAM_RGN_RSV :
                       hit[4] ? IAM_RGN_RO  :
                       hit[5] ? IAM_RGN_IFR :
                       hit[6] ? IAM_RGN_PFL : IAM_RGN_UNMAP;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      region <= IAM_RGN_UNMAP;
    end else if (clkEn) begin
      region <= next_region;
    end
  end
endmodule

// ### design/illegal_access_monitor.sv
// judges each bus access and reports illegal ones
`timescale 1ns/1ps
`include "iam_defs.svh"

// Summary of operation
// - judge every access by master, type, region
// - core reserved write legal only special single-chip
// - unservable NVM collision counts as illegal
// - core illegal access raises machine exception
// - debug illegal access sets debug status flag
module illegal_access_monitor #(
  parameter int ADDR_W = `IAM_ADDR_W
) (
  input  wire logic                core_clk,
  input  wire logic                resetn,
  input  wire logic                clkEn,
  input  wire logic                accValid,
  input  iam_pkg::iam_master_t     accMaster,
  input  iam_pkg::iam_access_t     accType,
  input  wire logic [ADDR_W-1:0]   accAddr,
  input  wire logic                nvmCmdBusy,
  input  wire logic                nvmCanService,
  input  wire logic                specialSingleChip,
  input  wire logic                illegalAccessFlagClr,
  output logic                     machineException,
  output logic                     illegal_access_flag,
  output logic                     accIllegal,
  output logic                     accLegal
);
  import iam_pkg::*;

  // refuse widths the fixed memory map cannot serve
  if (ADDR_W != `IAM_ADDR_W) begin : g_bad_width
    $error("illegal_access_monitor: address width must be 24");
  end

  // the region code is three bits wide
  if (`IAM_N_REGIONS != 8) begin : g_bad_regions
    $error("illegal_access_monitor: region table must hold 8 entries");
  end

  //////////////////////////////////////////////////////////////////////////
  // stage 1: capture access, decode region

  iam_region_t region;
  logic        stValid;
  iam_master_t stMaster;
  iam_access_t stType;
  logic        stCollide;
  logic        modeSs;

  iam_region_decode #(
    .ADDR_W (ADDR_W)
  ) u_decode (
    .core_clk (core_clk),
    .resetn   (resetn),
    .clkEn    (clkEn),
    .addr     (accAddr),
    .region   (region)
  );

  function automatic logic inWindow(input logic [ADDR_W-1:0] adr,
                                    input logic [ADDR_W-1:0] lo,
                                    input logic [ADDR_W-1:0] hi);
    inWindow = (adr >= lo) && (adr <= hi);
  endfunction

  wire nvmEe;
  wire nvmIfr;
  wire nvmPfl;
  wire nvmTarget;
  wire collideNow;
  assign nvmEe     = inWindow(accAddr, `IAM_EE_BASE, `IAM_EE_LAST);
  assign nvmIfr    = inWindow(accAddr, `IAM_IFR_BASE, `IAM_IFR_LAST);
  assign nvmPfl    = inWindow(accAddr, `IAM_PFL_BASE, `IAM_PFL_LAST);
  assign nvmTarget = nvmEe || nvmIfr || nvmPfl;
  assign collideNow = nvmTarget && nvmCmdBusy && !nvmCanService;

  // stage registers, frozen while clkEn is low
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stValid <= 1'b0;
    end else if (clkEn) begin
      stValid <= accValid;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stMaster <= IAM_MST_CORE;
    end else if (clkEn) begin
      stMaster <= accMaster;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stType <= IAM_ACC_READ;
    end else if (clkEn) begin
      stType <= accType;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stCollide <= 1'b0;
    end else if (clkEn) begin
      stCollide <= accValid && collideNow;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      modeSs <= 1'b0;
    end else if (clkEn) begin
      modeSs <= specialSingleChip;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // permission matrix

  function automatic logic permitted(input iam_master_t m,
                                     input iam_access_t t,
                                     input iam_region_t r,
                                     input logic        ss);
    logic conv;
    logic core;
    conv = (m == IAM_MST_CONV);
    core = (m == IAM_MST_CORE);
    permitted = 1'b0;
    case (t)
      IAM_ACC_READ: begin
        case (r)
          IAM_RGN_RAM, IAM_RGN_EE, IAM_RGN_PFL: permitted = 1'b1;
          IAM_RGN_REG, IAM_RGN_RSV, IAM_RGN_RO, IAM_RGN_IFR:
            permitted = !conv;
          default: permitted = 1'b0;
        endcase
      end
      IAM_ACC_WRITE: begin
        case (r)
          IAM_RGN_RAM: permitted = 1'b1;
          IAM_RGN_REG: permitted = !conv;
          IAM_RGN_RSV: permitted = core ? ss : !conv;
          default:     permitted = 1'b0;
        endcase
      end
      IAM_ACC_FETCH: begin
        case (r)
          IAM_RGN_RAM, IAM_RGN_EE, IAM_RGN_PFL: permitted = core;
          default: permitted = 1'b0;
        endcase
      end
      default: permitted = 1'b0;
    endcase
  endfunction

  // permission of the staged access in every region
  logic [`IAM_N_REGIONS-1:0] allowIn;

  for (genvar ri = 0; ri < `IAM_N_REGIONS; ri++) begin : g_allow
    assign allowIn[ri] = permitted(stMaster, stType,
                                   iam_region_t'(3'(ri)), modeSs);
  end

  //////////////////////////////////////////////////////////////////////////
  // verdict and reporting

  wire stIsCore;
  wire stIsDebug;
  wire regionOk;
  wire verdictIllegal;
  wire next_exception;
  wire next_flag;
  wire next_legal;

  assign stIsCore  = (stMaster == IAM_MST_CORE);
  assign stIsDebug = (stMaster == IAM_MST_DEBUG);
  assign regionOk  = allowIn[region];
  assign verdictIllegal = stValid && (!regionOk || stCollide);
  assign next_exception = verdictIllegal && stIsCore;
  // sticky debug flag, set beats clear
  assign next_flag = (verdictIllegal && stIsDebug)
                  || (illegal_access_flag && !illegalAccessFlagClr);
  assign next_legal = stValid && !verdictIllegal;

  // registered outputs, one flop each
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      machineException <= 1'b0;
    end else if (clkEn) begin
      machineException <= next_exception;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      illegal_access_flag <= `IAM_FLAG_RESET;
    end else if (clkEn) begin
      illegal_access_flag <= next_flag;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      accIllegal <= 1'b0;
    end else if (clkEn) begin
      accIllegal <= verdictIllegal;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      accLegal <= 1'b0;
    end else if (clkEn) begin
      accLegal <= next_legal;
    end
  end
endmodule

// ### verif/iam_asserts.sv
// port checks of the illegal access monitor
`timescale 1ns/1ps
`include "iam_defs.svh"
module iam_asserts #(
  parameter int ADDR_W = `IAM_ADDR_W
) (
  input wire logic            core_clk,
  input wire logic            resetn,
  input wire logic            clkEn,
  input wire logic            accValid,
  input iam_pkg::iam_master_t accMaster,
  input iam_pkg::iam_access_t accType,
  input wire logic [ADDR_W-1:0] accAddr,
  input wire logic            nvmCmdBusy,
  input wire logic            nvmCanService,
  input wire logic            specialSingleChip,
  input wire logic            illegalAccessFlagClr,
  input wire logic            machineException,
  input wire logic            illegal_access_flag,
  input wire logic            accIllegal,
  input wire logic            accLegal
);
  import iam_pkg::*;
  wire take = accValid && clkEn;
  wire core = accMaster == IAM_MST_CORE;
  wire isRsv = accAddr >= `IAM_RSV_BASE && accAddr <= `IAM_RSV_LAST;
  wire isEe = accAddr >= `IAM_EE_BASE && accAddr <= `IAM_EE_LAST;
  wire isGap = accAddr > `IAM_RAM_LAST && accAddr < `IAM_EE_BASE;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_verdict_exclusive: assert property (take ##1 clkEn |=> accIllegal ^ accLegal)
    else $error("verdict not exclusive");
  a_no_spurious: assert property (!accValid && clkEn ##1 clkEn |=> !accIllegal && !accLegal)
    else $error("verdict without access");
  a_rsv_core_write: assert property (take && core && accType == IAM_ACC_WRITE && isRsv ##1 clkEn |=> accIllegal != $past(specialSingleChip, 2))
    else $error("reserved write verdict wrong");
  a_nvm_collision: assert property (take && isEe && nvmCmdBusy && !nvmCanService ##1 clkEn |=> accIllegal)
    else $error("collision not illegal");
  a_core_exception: assert property (take ##1 clkEn |=> machineException == (accIllegal && $past(core, 2)))
    else $error("exception mismatch");
  a_flag_set: assert property (take && accMaster == IAM_MST_DEBUG ##1 clkEn ##1 accIllegal |-> illegal_access_flag)
    else $error("debug flag not set");
  a_flag_hold: assert property (illegal_access_flag && !illegalAccessFlagClr && clkEn |=> illegal_access_flag)
    else $error("debug flag dropped");
  a_gap_illegal: assert property (take && isGap ##1 clkEn |=> accIllegal)
    else $error("unmapped access legal");
  c_exception: cover property (machineException);
  c_legal: cover property (accLegal);
  c_clear: cover property (illegal_access_flag && illegalAccessFlagClr);
  c_collide: cover property (take && nvmCmdBusy && !nvmCanService);
  c_freeze: cover property (!clkEn && accIllegal);
endmodule

// ### verif/iam_master_model.sv
// bus master model presenting one access per request
`timescale 1ns/1ps
module iam_master_model (
  input wire logic        core_clk,
  input wire logic        go,
  input iam_pkg::iam_master_t m,
  input iam_pkg::iam_access_t t,
  input wire logic [23:0] a,
  output logic            accValid,
  output iam_pkg::iam_master_t accMaster,
  output iam_pkg::iam_access_t accType,
  output logic [23:0]     accAddr
);
  import iam_pkg::*;
  initial begin
    accValid = 1'b0;
    accMaster = IAM_MST_CORE;
    accType = IAM_ACC_READ;
    accAddr = 24'h000000;
  end
  always @(posedge core_clk) begin
    accValid <= go;
    accMaster <= m;
    accType <= t;
    // idle address shows inverse
    accAddr <= go ? a : ~accAddr;
  end
endmodule

// ### verif/testbench.sv
// self-checking bench of the illegal access monitor
`timescale 1ns/1ps
`include "iam_defs.svh"
module testbench;
  import iam_pkg::*;
  logic core_clk = 1'b0, resetn = 1'b0, clkEn = 1'b1, go = 1'b0;
  logic nvmCmdBusy = 1'b0, nvmCanService = 1'b1;
  logic specialSingleChip = 1'b0, illegalAccessFlagClr = 1'b0;
  iam_master_t m = IAM_MST_CORE, accMaster;
  iam_access_t t = IAM_ACC_READ, accType;
  logic [23:0] a = 24'h000000, accAddr;
  logic accValid, machineException, illegal_access_flag;
  logic accIllegal, accLegal;
  int err_total = 0, tests_run = 0;
  iam_master_model mst_u (.*);
  illegal_access_monitor dut_u (.*);
  initial forever #2.5 core_clk = ~core_clk;
  task automatic chk(string n, logic e, logic g);
    tests_run++;
    if (e !== g) begin
      err_total++;
      $display("[ERR] %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic acc(iam_master_t mi, iam_access_t ti, logic [23:0] ai,
                     logic e);
    @(posedge core_clk);
    go <= 1'b1;
    m <= mi;
    t <= ti;
    a <= ai;
    @(posedge core_clk);
    go <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk("accIllegal", e, accIllegal);
    chk("accLegal", !e, accLegal);
    chk("machineException", e && mi == IAM_MST_CORE,
        machineException);
    if (e && mi == IAM_MST_DEBUG)
      chk("flag", 1'b1, illegal_access_flag);
  endtask
  task automatic t_matrix();
    acc(IAM_MST_CORE, IAM_ACC_READ, 24'h000010, 1'b0);
    acc(IAM_MST_CORE, IAM_ACC_FETCH, 24'h000010, 1'b1);
    acc(IAM_MST_CONV, IAM_ACC_READ, 24'h000FFF, 1'b1);
    acc(IAM_MST_CONV, IAM_ACC_WRITE, 24'h0017FF, 1'b0);
    acc(IAM_MST_DEBUG, IAM_ACC_READ, 24'h001800, 1'b1);
    acc(IAM_MST_DEBUG, IAM_ACC_FETCH, 24'h001000, 1'b1);
    acc(IAM_MST_CORE, IAM_ACC_WRITE, 24'h300000, 1'b1);
    acc(IAM_MST_CORE, IAM_ACC_FETCH, 24'hFFC000, 1'b0);
    acc(IAM_MST_CONV, IAM_ACC_READ, 24'h400000, 1'b1);
    acc(IAM_MST_CORE, IAM_ACC_WRITE, 24'h100000, 1'b1);
    acc(iam_master_t'(2'h3), IAM_ACC_READ, 24'h001000, 1'b0);
    acc(IAM_MST_CORE, iam_access_t'(2'h3), 24'h001000, 1'b1);
    $display("test matrix done");
  endtask
  task automatic t_rsv();
    acc(IAM_MST_CORE, IAM_ACC_WRITE, 24'h200010, 1'b1);
    @(posedge core_clk);
    specialSingleChip <= 1'b1;
    acc(IAM_MST_CORE, IAM_ACC_WRITE, 24'h2FFFFF, 1'b0);
    @(posedge core_clk);
    specialSingleChip <= 1'b0;
    acc(IAM_MST_DEBUG, IAM_ACC_WRITE, 24'h200000, 1'b0);
    $display("test reserved done");
  endtask
  task automatic t_nvm();
    @(posedge core_clk);
    nvmCmdBusy <= 1'b1;
    nvmCanService <= 1'b0;
    acc(IAM_MST_CORE, IAM_ACC_READ, 24'h100000, 1'b1);
    acc(IAM_MST_DEBUG, IAM_ACC_READ, 24'hFFC000, 1'b1);
    acc(IAM_MST_CONV, IAM_ACC_READ, 24'hFFFFFF, 1'b1);
    acc(IAM_MST_CORE, IAM_ACC_READ, 24'h001000, 1'b0);
    @(posedge core_clk);
    nvmCanService <= 1'b1;
    acc(IAM_MST_CORE, IAM_ACC_READ, 24'h10007F, 1'b0);
    @(posedge core_clk);
    nvmCmdBusy <= 1'b0;
    $display("test collision done");
  endtask
  task automatic t_flag();
    @(posedge core_clk);
    illegalAccessFlagClr <= 1'b1;
    @(posedge core_clk);
    illegalAccessFlagClr <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("flag", 1'b0, illegal_access_flag);
    acc(IAM_MST_CONV, IAM_ACC_READ, 24'h000FFF, 1'b1);
    chk("flagConv", 1'b0, illegal_access_flag);
    acc(IAM_MST_CORE, IAM_ACC_FETCH, 24'h000010, 1'b1);
    chk("flagCore", 1'b0, illegal_access_flag);
    @(posedge core_clk);
    go <= 1'b1;
    m <= IAM_MST_DEBUG;
    t <= IAM_ACC_WRITE;
    a <= 24'h300000;
    @(posedge core_clk);
    go <= 1'b0;
    @(posedge core_clk);
    illegalAccessFlagClr <= 1'b1;
    @(posedge core_clk);
    illegalAccessFlagClr <= 1'b0;
    #1;
    chk("flagSetWins", 1'b1, illegal_access_flag);
    acc(IAM_MST_DEBUG, IAM_ACC_WRITE, 24'h100000, 1'b1);
    $display("test flag done");
  endtask
  task automatic t_freeze();
    @(posedge core_clk);
    go <= 1'b1;
    m <= IAM_MST_CORE;
    t <= IAM_ACC_FETCH;
    a <= 24'h000020;
    @(posedge core_clk);
    go <= 1'b0;
    repeat (2) @(posedge core_clk);
    clkEn <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk("frozenIllegal", 1'b1, accIllegal);
    chk("frozenException", 1'b1, machineException);
    @(posedge core_clk);
    clkEn <= 1'b1;
    @(posedge core_clk);
    #1;
    chk("thawedIllegal", 1'b0, accIllegal);
    chk("thawedException", 1'b0, machineException);
    $display("test freeze done");
  endtask
  task automatic t_reset();
    acc(IAM_MST_DEBUG, IAM_ACC_FETCH, 24'h400000, 1'b1);
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk("resetFlag", `IAM_FLAG_RESET, illegal_access_flag);
    chk("resetIllegal", 1'b0, accIllegal);
    chk("resetException", 1'b0, machineException);
    @(posedge core_clk);
    resetn <= 1'b1;
    acc(IAM_MST_CORE, IAM_ACC_READ, 24'h001000, 1'b0);
    $display("test reset done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    t_matrix();
    t_rsv();
    t_nvm();
    t_flag();
    t_freeze();
    t_reset();
    end_of_test();
  end
  initial begin
    #5000;
    err_total++;
    end_of_test();
  end
endmodule
bind illegal_access_monitor iam_asserts #(.ADDR_W(ADDR_W)) chk_u (.*);
